//--- common/vih_pkg.sv
// Purpose: Shared constants, types and helpers of the vectored interrupt handler
// Assumes: One system clock, 8-bit register port
// Notes: Source index equals fixed rank; rank 0 is served first within a level
package vih_pkg;

  localparam int NUM_SRC = 22;
  localparam int NUM_PERIPH = 12;
  localparam int NUM_EXT_MAX = 10;
  localparam int NUM_PINS = 6;
  localparam int NUM_EXT47 = 4;

  // Fixed ranks of the pin sources that the handler itself flags, and of crystal ready
  localparam logic [4:0] SRC_EXT0 = 5'h00;
  localparam logic [4:0] SRC_EXT1 = 5'h02;
  localparam int SRC_EXT4 = 16;
  localparam int SRC_XTAL = 21;

  // Synchronised pin positions
  localparam int PIN_EXT0 = 0;
  localparam int PIN_EXT1 = 1;
  localparam int PIN_EXT4 = 2;

  // Vector table
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;

  // Register map
  localparam logic [7:0] REG_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] REG_PORT1_IRQ_FLAG = 8'h01;
  localparam logic [7:0] REG_PEND0 = 8'h02;
  localparam logic [7:0] REG_PEND1 = 8'h03;
  localparam logic [7:0] REG_PEND2 = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_SOURCE = 8'h06;

  // Field positions
  localparam int TC_EXT0_TRIGGER_TYPE = 0;
  localparam int TC_EXT0_PENDING_FLAG = 1;
  localparam int TC_EXT1_TRIGGER_TYPE = 2;
  localparam int TC_EXT1_PENDING_FLAG = 3;
  localparam int P1IF_EXT4_FLAG = 4;
  localparam int PEND_BYTE_W = 8;
  localparam int PEND0_LSB = 0;
  localparam int PEND1_LSB = 8;
  localparam int PEND2_LSB = 16;
  localparam int PEND2_W = 6;
  localparam int ST_IN_LOW = 0;
  localparam int ST_IN_HIGH = 1;
  localparam int ST_CALL_REQ = 2;

  typedef enum logic {VIH_IDLE, VIH_CALL} vih_state_t;

  typedef struct packed {
    vih_state_t st;
    logic [NUM_SRC-1:0] pend;
    logic it0;
    logic it1;
    logic [NUM_PINS-1:0] pin_prev;
    logic in_low;
    logic in_high;
    logic lvl_high;
    logic [4:0] src;
    logic [15:0] vec;
    logic call_req;
    logic [7:0] rdata;
  } vih_core_t;

  // Lowest set index, zero when none
  function automatic logic [4:0] vih_first(input logic [NUM_SRC-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : vih_first

  function automatic logic [15:0] vih_vector(input logic [4:0] idx);
    return VEC_FIRST + (16'(idx) << VEC_STEP_SHIFT);
  endfunction : vih_vector

endpackage : vih_pkg

//--- hdl/vih_sync.sv
// Purpose: Two-stage synchroniser for the external request pins
// Assumes: Pins idle high
// Notes: Only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module vih_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vih_sync_t;

  vih_sync_t q;
  vih_sync_t next_q;

  always_comb
  begin
    next_q.s1 = din;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign dout = q.s2;

endmodule : vih_sync
`default_nettype wire

//--- hdl/vih_arbiter.sv
// Purpose: Two-level fixed-rank arbiter
// Assumes: Requests already masked by the enables
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module vih_arbiter
  import vih_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req,
  input wire logic [NUM_SRC-1:0] prio_high,
  input wire logic in_low,
  input wire logic in_high,
  output logic win_valid,
  output logic win_high,
  output logic [4:0] win_idx
);

  logic [NUM_SRC-1:0] req_hi;
  logic [NUM_SRC-1:0] req_lo;

  always_comb
  begin
    // High level waits only on a high routine
    req_hi = in_high ? '0 : (req & prio_high);
    // Low level waits on any routine in service
    req_lo = (in_high || in_low) ? '0 : (req & ~prio_high);
    win_high = |req_hi;
    win_valid = win_high || (|req_lo);
    // Lower rank wins inside a level
    win_idx = win_high ? vih_first(req_hi) : vih_first(req_lo);
  end

endmodule : vih_arbiter
`default_nettype wire

//--- hdl/vih_top.sv
// Purpose: Vectored interrupt handler with two priority levels
// Assumes: Core pulses instruction end, return end and call taken
// Notes: Pins pass a two-stage synchroniser
//
// Overview of operation
// - Arbitrate 22 sources on two levels
// - Twelve peripheral sources, up to ten external
// - Source requests when any of its flags set
// - Flag sets regardless of enable state
// - Disabled pending flag makes no request
// - Global enable gates every source enable
// - After instruction ends, long call to vector
// - Return resumes the interrupted instruction stream
// - Still-pending flag requests again after return
// - Software write of one acts as interrupt
// - Ext0/ext1 low level or falling edge
// - Ext0/ext1 flags at control bits 1, 3
// - Edge mode flag cleared on vectoring
// - Level mode flag mirrors the pin
// - Ext4-7 falling edge, flags in port1 register
// - Vectors start 0x0003, step eight bytes
// - Ranks 0 to 21, crystal ready last
// - High preempts low, high never preempted
// - Equal level: lower rank served first
// - Sample every clock, detect then call
// - Equal or lower waits for return plus one
`timescale 1ns/1ps
`default_nettype none
module vih_top
  import vih_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [NUM_SRC-1:0] SRC_ENABLE,
  input wire logic [NUM_SRC-1:0] SRC_PRIO_HIGH,
  input wire logic [NUM_SRC-1:0] PERIPH_EVENT,
  input wire logic [NUM_SRC-1:0] PERIPH_FLAGS,
  input wire logic EXT0_REQUEST_PIN_N,
  input wire logic EXT1_REQUEST_PIN_N,
  input wire logic [NUM_EXT47-1:0] EXT47_REQUEST_PIN_N,
  input wire logic CORE_INSTR_DONE,
  input wire logic CORE_RETURN_FROM_IRQ_INSTR_DONE,
  input wire logic CORE_CALL_ACK,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic CALL_REQ,
  output logic [15:0] CALL_VECTOR,
  output logic [4:0] CALL_SOURCE,
  output logic IN_SERVICE_LOW,
  output logic IN_SERVICE_HIGH
);

  vih_core_t q;
  vih_core_t next_q;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_SRC-1:0] req;
  logic win_valid;
  logic win_high;
  logic [4:0] win_idx;
  logic [NUM_SRC-1:0] hw_set;
  logic [NUM_SRC-1:0] hw_clr;

  vih_sync #(
    .W(NUM_PINS)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .din({EXT47_REQUEST_PIN_N, EXT1_REQUEST_PIN_N, EXT0_REQUEST_PIN_N}),
    .dout(pin_s)
  );

  // Source request from own flag or peripheral-held flags
  assign req = (q.pend | PERIPH_FLAGS) & SRC_ENABLE & {NUM_SRC{GLOBAL_IRQ_ENABLE}};

  vih_arbiter u_arb (
    .req(req),
    .prio_high(SRC_PRIO_HIGH),
    .in_low(q.in_low),
    .in_high(q.in_high),
    .win_valid(win_valid),
    .win_high(win_high),
    .win_idx(win_idx)
  );

  always_comb
  begin
    logic [NUM_PINS-1:0] fell;
    logic [NUM_SRC-1:0] sw_mask;
    logic [NUM_SRC-1:0] sw_val;
    fell = '0;
    sw_mask = '0;
    sw_val = '0;
    next_q = q;
    next_q.rdata = 8'h00;
    next_q.pin_prev = pin_s;
    fell = q.pin_prev & ~pin_s;
    // Hardware events
    hw_set = PERIPH_EVENT;
    hw_set[SRC_EXT0] = PERIPH_EVENT[SRC_EXT0] | (q.it0 & fell[PIN_EXT0]);
    hw_set[SRC_EXT1] = PERIPH_EVENT[SRC_EXT1] | (q.it1 & fell[PIN_EXT1]);
    for (int j = 0; j < NUM_EXT47; j++)
    begin
      hw_set[SRC_EXT4 + j] = PERIPH_EVENT[SRC_EXT4 + j] | fell[PIN_EXT4 + j];
    end
    hw_clr = '0;
    if (q.st == VIH_CALL && CORE_CALL_ACK)
    begin
      hw_clr[SRC_EXT0] = q.it0 && (q.src == SRC_EXT0);
      hw_clr[SRC_EXT1] = q.it1 && (q.src == SRC_EXT1);
    end
    // Register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        REG_TIMER_CONTROL:
        begin
          next_q.it0 = REG_WDATA[TC_EXT0_TRIGGER_TYPE];
          next_q.it1 = REG_WDATA[TC_EXT1_TRIGGER_TYPE];
          sw_mask[SRC_EXT0] = 1'b1;
          sw_mask[SRC_EXT1] = 1'b1;
          sw_val[SRC_EXT0] = REG_WDATA[TC_EXT0_PENDING_FLAG];
          sw_val[SRC_EXT1] = REG_WDATA[TC_EXT1_PENDING_FLAG];
        end
        REG_PORT1_IRQ_FLAG:
        begin
          for (int j = 0; j < NUM_EXT47; j++)
          begin
            sw_mask[SRC_EXT4 + j] = 1'b1;
            sw_val[SRC_EXT4 + j] = REG_WDATA[P1IF_EXT4_FLAG + j];
          end
        end
        REG_PEND0:
        begin
          sw_mask[PEND0_LSB +: PEND_BYTE_W] = '1;
          sw_val[PEND0_LSB +: PEND_BYTE_W] = REG_WDATA;
        end
        REG_PEND1:
        begin
          sw_mask[PEND1_LSB +: PEND_BYTE_W] = '1;
          sw_val[PEND1_LSB +: PEND_BYTE_W] = REG_WDATA;
        end
        REG_PEND2:
        begin
          sw_mask[PEND2_LSB +: PEND2_W] = '1;
          sw_val[PEND2_LSB +: PEND2_W] = REG_WDATA[PEND2_W-1:0];
        end
        default:
        begin
          sw_mask = '0;
        end
      endcase
    end
    // Software write of one is a genuine request; hardware set wins
    next_q.pend = (((q.pend & ~sw_mask) | (sw_val & sw_mask)) & ~hw_clr) | hw_set;
    if (!q.it0)
    begin
      next_q.pend[SRC_EXT0] = ~pin_s[PIN_EXT0];
    end
    if (!q.it1)
    begin
      next_q.pend[SRC_EXT1] = ~pin_s[PIN_EXT1];
    end
    // Register reads
    if (REG_RD)
    begin
      case (REG_ADDR)
        REG_TIMER_CONTROL:
        begin
          next_q.rdata[TC_EXT0_TRIGGER_TYPE] = q.it0;
          next_q.rdata[TC_EXT0_PENDING_FLAG] = q.pend[SRC_EXT0];
          next_q.rdata[TC_EXT1_TRIGGER_TYPE] = q.it1;
          next_q.rdata[TC_EXT1_PENDING_FLAG] = q.pend[SRC_EXT1];
        end
        REG_PORT1_IRQ_FLAG:
        begin
          next_q.rdata[P1IF_EXT4_FLAG +: NUM_EXT47] = q.pend[SRC_EXT4 +: NUM_EXT47];
        end
        REG_PEND0:
        begin
          next_q.rdata = q.pend[PEND0_LSB +: PEND_BYTE_W];
        end
        REG_PEND1:
        begin
          next_q.rdata = q.pend[PEND1_LSB +: PEND_BYTE_W];
        end
        REG_PEND2:
        begin
          next_q.rdata[PEND2_W-1:0] = q.pend[PEND2_LSB +: PEND2_W];
        end
        REG_STATUS:
        begin
          next_q.rdata[ST_IN_LOW] = q.in_low;
          next_q.rdata[ST_IN_HIGH] = q.in_high;
          next_q.rdata[ST_CALL_REQ] = q.call_req;
        end
        REG_SOURCE:
        begin
          next_q.rdata[4:0] = q.src;
        end
        default:
        begin
          next_q.rdata = 8'h00;
        end
      endcase
    end
    // Return ends the innermost routine
    if (CORE_RETURN_FROM_IRQ_INSTR_DONE)
    begin
      if (q.in_high)
      begin
        next_q.in_high = 1'b0;
      end
      else
      begin
        next_q.in_low = 1'b0;
      end
    end
    case (q.st)
      VIH_IDLE:
      begin
        // Instruction boundary other than the return itself
        if (CORE_INSTR_DONE && !CORE_RETURN_FROM_IRQ_INSTR_DONE && win_valid)
        begin
          next_q.st = VIH_CALL;
          next_q.call_req = 1'b1;
          next_q.src = win_idx;
          next_q.vec = vih_vector(win_idx);
          next_q.lvl_high = win_high;
        end
      end
      VIH_CALL:
      begin
        if (CORE_CALL_ACK)
        begin
          next_q.st = VIH_IDLE;
          next_q.call_req = 1'b0;
          if (q.lvl_high)
          begin
            next_q.in_high = 1'b1;
          end
          else
          begin
            next_q.in_low = 1'b1;
          end
        end
      end
      default:
      begin
        next_q.st = VIH_IDLE;
        next_q.call_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q.st <= VIH_IDLE;
      q.pend <= '0;
      q.it0 <= 1'b0;
      q.it1 <= 1'b0;
      q.pin_prev <= '1;
      q.in_low <= 1'b0;
      q.in_high <= 1'b0;
      q.lvl_high <= 1'b0;
      q.src <= 5'h00;
      q.vec <= VEC_RESET;
      q.call_req <= 1'b0;
      q.rdata <= 8'h00;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign REG_RDATA = q.rdata;
  assign CALL_REQ = q.call_req;
  assign CALL_VECTOR = q.vec;
  assign CALL_SOURCE = q.src;
  assign IN_SERVICE_LOW = q.in_low;
  assign IN_SERVICE_HIGH = q.in_high;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_detect;
    q.st == VIH_IDLE && CORE_INSTR_DONE && !CORE_RETURN_FROM_IRQ_INSTR_DONE && win_valid;
  endsequence

  sequence s_call_taken;
    q.st == VIH_CALL && CORE_CALL_ACK;
  endsequence

  a_call_latency: assert property (s_detect |=> CALL_REQ && CALL_SOURCE == $past(win_idx))
    else $error("call not raised one cycle after detection");
  a_vector_map: assert property (CALL_REQ |-> CALL_VECTOR == VEC_FIRST + 16'(CALL_SOURCE) * 16'h0008)
    else $error("vector does not match source");
  a_call_hold: assert property (CALL_REQ && !CORE_CALL_ACK |=> CALL_REQ && $stable(CALL_VECTOR))
    else $error("call dropped before the core took it");
  a_no_call_return_from_irq_instr: assert property (CORE_RETURN_FROM_IRQ_INSTR_DONE |=> !$rose(CALL_REQ))
    else $error("call raised at the return boundary");
  a_global_off: assert property (!GLOBAL_IRQ_ENABLE && q.st == VIH_IDLE |=> !CALL_REQ)
    else $error("call raised with global enable off");
  a_high_no_preempt: assert property (IN_SERVICE_HIGH |=> !$rose(CALL_REQ))
    else $error("high routine preempted");
  a_edge_clear: assert property (s_call_taken ##0 (q.src == SRC_EXT0 && q.it0 && !hw_set[SRC_EXT0])
    |=> !q.pend[SRC_EXT0])
    else $error("edge flag not cleared on vectoring");
  a_level_mirror: assert property (!q.it0 && !REG_WR ##1 !q.it0 |-> q.pend[SRC_EXT0] == !$past(pin_s[PIN_EXT0]))
    else $error("level flag does not follow pin");
  a_set_wins: assert property (|hw_set |=> (q.pend & $past(hw_set)) == $past(hw_set))
    else $error("hardware event lost");
  a_sw_set: assert property (REG_WR && REG_ADDR == REG_PEND1 |=>
    (q.pend[PEND1_LSB +: PEND_BYTE_W] & $past(REG_WDATA)) == $past(REG_WDATA))
    else $error("software set of a flag ignored");
  a_enter_level: assert property (s_call_taken |=> IN_SERVICE_HIGH || IN_SERVICE_LOW)
    else $error("service level not recorded");

endmodule : vih_top
`default_nettype wire

//--- bench/vih_core_model.sv
// Purpose: Core sequencer model facing the handler
// Assumes: Call taken after a set delay
// Notes: No instruction ends after the first cycle of a pending call
`timescale 1ns/1ps
`default_nettype none
module vih_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic call_req,
  input wire logic return_from_irq_instr_go,
  input wire logic [2:0] ack_dly,
  output logic instr_done,
  output logic return_from_irq_instr_done,
  output logic call_ack
);
  logic [2:0] cnt;
  always_ff @(posedge clk)
  begin
    instr_done <= 1'h0;
    return_from_irq_instr_done <= 1'h0;
    call_ack <= 1'h0;
    if (rst)
      cnt <= 3'h0;
    else if (call_req && !call_ack)
    begin
      // Long call takes a variable time
      cnt <= (cnt == ack_dly) ? 3'h0 : cnt + 3'h1;
      call_ack <= (cnt == ack_dly);
    end
    else if (return_from_irq_instr_go)
    begin
      instr_done <= 1'h1;
      return_from_irq_instr_done <= 1'h1;
    end
    else
      instr_done <= 1'h1;
  end
endmodule : vih_core_model
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench of the interrupt handler
// Assumes: Core model answers calls
// Notes: Random sources with fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vih_pkg::*;
;
  logic clk, rst, ge, p0, p1, wr, rd, creq, isl, ish, idone, rdone, ack, rgo, ph_s;
  logic [NUM_SRC-1:0] en, ph, ev, fl;
  logic [3:0] p47;
  logic [7:0] ra, wd, rdata, q;
  logic [15:0] cvec;
  logic [4:0] csrc, s;
  logic [2:0] dly;
  int bad_count, check_count, cyc;

  vih_top i_vih_top (
    .CLK(clk), .RST(rst), .GLOBAL_IRQ_ENABLE(ge), .SRC_ENABLE(en), .SRC_PRIO_HIGH(ph),
    .PERIPH_EVENT(ev), .PERIPH_FLAGS(fl), .EXT0_REQUEST_PIN_N(p0), .EXT1_REQUEST_PIN_N(p1),
    .EXT47_REQUEST_PIN_N(p47), .CORE_INSTR_DONE(idone), .CORE_RETURN_FROM_IRQ_INSTR_DONE(rdone),
    .CORE_CALL_ACK(ack), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .CALL_REQ(creq), .CALL_VECTOR(cvec), .CALL_SOURCE(csrc),
    .IN_SERVICE_LOW(isl), .IN_SERVICE_HIGH(ish)
  );
  vih_core_model i_vih_core_model (
    .clk(clk), .rst(rst), .call_req(creq), .return_from_irq_instr_go(rgo), .ack_dly(dly),
    .instr_done(idone), .return_from_irq_instr_done(rdone), .call_ack(ack)
  );

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] exp_vec(input logic [4:0] r);
    return 16'h0003 + 16'(r) * 16'h0008;
  endfunction : exp_vec

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    ra <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1 q = rdata;
    @(posedge clk);
  endtask : bus

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic pulse(input logic [NUM_SRC-1:0] m);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask : pulse

  task automatic serve(input logic [4:0] r, input logic hi);
    int n;
    n = 0;
    while (creq !== 1'h1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    chk(creq, 1'h1);
    chk(cvec, exp_vec(r));
    chk(csrc, r);
    while (ack !== 1'h1 && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk(creq, 1'h0);
    chk(hi ? ish : isl, 1'h1);
  endtask : serve

  task automatic ret(input logic [4:0] r, input logic c);
    if (c)
    begin
      // Read-modify-write keeps the other flags of the byte
      fl[r] <= 1'h0;
      bus(1'h0, REG_PEND0 + 8'(r >> 3), 8'h00);
      bus(1'h1, REG_PEND0 + 8'(r >> 3), q & ~(8'h01 << r[2:0]));
    end
    rgo <= 1'h1;
    @(posedge clk);
    rgo <= 1'h0;
  endtask : ret

  initial
  begin
    {rst, ge, en, ph, ev, fl, p0, p1, p47} = {1'h1, 1'h0, 88'h0, 1'h1, 1'h1, 4'hf};
    {ra, wd, wr, rd, rgo, dly, s, q, ph_s} = '0;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(36593));
    idle(16);
    rst <= 1'h0;
    ge <= 1'h1;
    en <= 22'h3fffdf;
    @(posedge clk);
    chk(cvec, 16'h0000);
    bus(1'h1, 8'h07, 8'hff);
    for (int a = 0; a < 8; a++)
    begin
      bus(1'h0, 8'(a), 8'h00);
      chk(q, 8'h00);
    end
    // Masking by source and by global enable
    pulse(22'h000020);
    idle(12);
    chk(creq, 1'h0);
    bus(1'h0, REG_PEND0, 8'h00);
    chk(q, 8'h20);
    en <= '1;
    ge <= 1'h0;
    idle(12);
    chk(creq, 1'h0);
    ge <= 1'h1;
    serve(5'h05, 1'h0);
    ret(5'h05, 1'h1);
    // Random sources, three ways of raising
    for (int i = 0; i < 14; i++)
    begin
      s = 5'($urandom % 18);
      if (s == 5'h00 || s == 5'h02)
        s = s + 5'h01;
      if (s > 5'h0f)
        s = s + 5'h04;
      ph_s = 1'($urandom);
      ph <= {NUM_SRC{ph_s}};
      dly <= 3'($urandom % 4);
      case (2'($urandom % 3))
        2'h0: pulse(NUM_SRC'(1) << s);
        2'h1: fl[s] <= 1'h1;
        default: bus(1'h1, REG_PEND0 + 8'(s >> 3), 8'h01 << s[2:0]);
      endcase
      serve(s, ph_s);
      ret(s, 1'h1);
      idle(4);
    end
    // Ties, preemption and waiting
    ph <= 22'h002000;
    dly <= 3'h3;
    pulse(22'h000210);
    serve(5'h04, 1'h0);
    pulse(22'h202000);
    serve(5'h0d, 1'h1);
    chk(isl, 1'h1);
    idle(10);
    chk(creq, 1'h0);
    ret(5'h0d, 1'h1);
    idle(8);
    chk(creq, 1'h0);
    ret(5'h04, 1'h1);
    serve(5'h09, 1'h0);
    ret(5'h09, 1'h1);
    serve(5'h15, 1'h0);
    ret(5'h15, 1'h1);
    // Flag left set re-enters after return
    pulse(22'h000040);
    serve(5'h06, 1'h0);
    ret(5'h06, 1'h0);
    serve(5'h06, 1'h0);
    ret(5'h06, 1'h1);
    // External pins in level and edge modes
    en <= 22'h3efffb;
    p1 <= 1'h0;
    p47 <= 4'he;
    idle(6);
    bus(1'h0, REG_TIMER_CONTROL, 8'h00);
    chk(q, 8'h08);
    bus(1'h0, REG_PORT1_IRQ_FLAG, 8'h00);
    chk(q, 8'h10);
    p1 <= 1'h1;
    p47 <= 4'hf;
    idle(6);
    bus(1'h0, REG_TIMER_CONTROL, 8'h00);
    chk(q, 8'h00);
    bus(1'h1, REG_PORT1_IRQ_FLAG, 8'h00);
    bus(1'h1, REG_TIMER_CONTROL, 8'h01);
    p0 <= 1'h0;
    serve(SRC_EXT0, 1'h0);
    bus(1'h0, REG_TIMER_CONTROL, 8'h00);
    chk(q, 8'h01);
    p0 <= 1'h1;
    ret(SRC_EXT0, 1'h0);
    idle(6);
    chk(creq, 1'h0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
